// >>> rtl/slpc_params.svh
`ifndef SLPC_PARAMS_SVH
`define SLPC_PARAMS_SVH

// Register byte addresses (word aligned)
`define SLPC_ADDR_CTRL 4'h0
`define SLPC_ADDR_STAT 4'h4
`define SLPC_ADDR_WAKE 4'h8
`define SLPC_ADDR_HIST 4'hC

// Control register fields
`define SLPC_CTRL_MODE_LO 0
`define SLPC_CTRL_MODE_HI 1
`define SLPC_CTRL_RXOFF 2
`define SLPC_CTRL_RXOFF_IN_PD 3
`define SLPC_CTRL_RESET 32'h0000_0000

// Status register fields
`define SLPC_STAT_COMBINED_SHUTDOWN_N 0
`define SLPC_STAT_OVRD 1
`define SLPC_STAT_RXOFF 2
`define SLPC_STAT_VALID 3
`define SLPC_STAT_PD 4
`define SLPC_STAT_TX_READY 5

// Timing at a 10 MHz clock
`define SLPC_CLK_NS 100
`define SLPC_RESUME_US 100
`define SLPC_RESUME_CYC ((`SLPC_RESUME_US * 1000) / `SLPC_CLK_NS)
`define SLPC_CNT_W 11

// History memory
`define SLPC_HIST_AW 3
`define SLPC_HIST_DW 8

`endif

// >>> rtl/slpc_pkg.sv
package slpc_pkg;
  typedef enum logic [2:0] {
    SLPC_MODE_ON = 3'b001,
    SLPC_MODE_AUTO = 3'b010,
    SLPC_MODE_OFF = 3'b100
  } slpc_mode_t;

  typedef enum logic [2:0] {
    SLPC_ST_SLEEP = 3'b001,
    SLPC_ST_WAKING = 3'b010,
    SLPC_ST_READY = 3'b100
  } slpc_state_t;
endpackage

// >>> rtl/slpc_hist_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "slpc_params.svh"

module slpc_hist_mem (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [`SLPC_HIST_AW-1:0] waddr_i,
  input wire logic [`SLPC_HIST_DW-1:0] wdata_i,
  input wire logic [`SLPC_HIST_AW-1:0] raddr_i,
  output logic [`SLPC_HIST_DW-1:0] rdata_o
);
  logic [`SLPC_HIST_DW-1:0] mem_r [0:(1<<`SLPC_HIST_AW)-1];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= mem_r[raddr_i];
  end
endmodule
`default_nettype wire

// >>> rtl/slpc_host.sv
// Behaviour
// [R1] Manual shutdown low forces powerdown; high permits operation.
// [R2] In powerdown the charge pump is off and transmitters float.
// [R3] Receivers stay driven in powerdown unless receiver tristate is high.
// [R4] Receiver tristate high floats all receiver outputs in every mode.
// [R5] Manual shutdown overrides the auto powerdown override input.
// [R6] Auto powerdown armed only with override low and shutdown high.
// [R7] Override and shutdown both high keep transmitters active regardless.
// [R8] Armed auto mode powers down after 30us without valid receiver levels.
// [R9] Armed auto mode wakes as soon as any receiver level is valid.
// [R10] Line-valid falls after all receivers invalid for over 30us.
// [R11] Line-valid rises 1us after a valid receiver level appears.
// [R12] Line-valid works in every mode, independent of control inputs.
// [R13] Transmission resumes within 100us after any powerdown exit.
// [R14] Auto mode returns to powerdown if no valid level within 30us.
// [R15] Single shutdown control means tying shutdown and override together.
// [R16] Strictly manual control holds override high.
// [R17] With auto powerdown in use, line-valid low means powered down.
// [R18] Host should also raise receiver tristate while shut down.
// [R19] With no powerdown needed, host holds shutdown high.
// [R20] Receiver validity is a digital detector flag; idle when all false.
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "slpc_params.svh"

module slpc_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic line_valid_i,
  output logic manual_shutdown_n_o,
  output logic auto_pd_override_o,
  output logic rx_tristate_o
);
  logic [31:0] ctrl_r;
  logic valid_s1_r;
  logic valid_s2_r;
  logic valid_d_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic [`SLPC_CNT_W-1:0] wake_cnt_r;
  logic [15:0] wake_total_r;
  logic tx_ready_r;
  logic [`SLPC_HIST_AW-1:0] hist_ptr_r;
  logic [`SLPC_HIST_DW-1:0] hist_rdata;
  slpc_pkg::slpc_mode_t mode;
  slpc_pkg::slpc_state_t state_r;
  logic combined_shutdown_n_nxt;
  logic ovrd_nxt;
  logic pd_now;
  logic wr_ctrl;
  logic bus_req;
  logic [1:0] fill_cnt_r;
  logic hist_we;

  function automatic slpc_pkg::slpc_mode_t decode_mode(
    input logic [1:0] f
  );
    case (f)
      2'b01: decode_mode = slpc_pkg::SLPC_MODE_AUTO;
      2'b10: decode_mode = slpc_pkg::SLPC_MODE_OFF;
      default: decode_mode = slpc_pkg::SLPC_MODE_ON;
    endcase
  endfunction

  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_ctrl = bus_req & wb_we_i & wb_sel_i[0] &
    (wb_adr_i == `SLPC_ADDR_CTRL);
  assign mode = decode_mode(ctrl_r[`SLPC_CTRL_MODE_HI:`SLPC_CTRL_MODE_LO]);

  // Pin drive per mode: on ties the two controls high alike, off holds override high [R15] [R16] [R19]
  always_comb begin
    case (mode)
      slpc_pkg::SLPC_MODE_OFF: begin
        combined_shutdown_n_nxt = 1'b0; // [R1] [R5]
        ovrd_nxt = 1'b1; // [R16]
      end
      slpc_pkg::SLPC_MODE_AUTO: begin
        combined_shutdown_n_nxt = 1'b1; // [R6]
        ovrd_nxt = 1'b0;
      end
      slpc_pkg::SLPC_MODE_ON: begin
        combined_shutdown_n_nxt = 1'b1; // [R7] [R19]
        ovrd_nxt = 1'b1;
      end
      default: begin
        combined_shutdown_n_nxt = 1'b1;
        ovrd_nxt = 1'b1;
      end
    endcase
  end

  // Device powerdown as the host infers it; auto mode trusts line-valid
  assign pd_now = ~manual_shutdown_n_o |
    (~auto_pd_override_o & ~valid_s2_r); // [R17] [R8] [R14]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `SLPC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= {28'h000_0000, wb_dat_i[3:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      manual_shutdown_n_o <= 1'b1;
      auto_pd_override_o <= 1'b1;
      rx_tristate_o <= 1'b0;
    end else begin
      manual_shutdown_n_o <= combined_shutdown_n_nxt;
      auto_pd_override_o <= ovrd_nxt;
      // Floating receivers while shut down saves the leakage path
      rx_tristate_o <= ctrl_r[`SLPC_CTRL_RXOFF] |
        (ctrl_r[`SLPC_CTRL_RXOFF_IN_PD] & ~combined_shutdown_n_nxt); // [R4] [R3] [R18]
    end
  end

  // Line-valid is an asynchronous pin; two stages before use [R12] [R20]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_s1_r <= 1'b0;
      valid_s2_r <= 1'b0;
      valid_d_r <= 1'b0;
      fill_cnt_r <= 2'h0;
    end else begin
      valid_s1_r <= line_valid_i;
      valid_s2_r <= valid_s1_r;
      valid_d_r <= valid_s2_r; // [R10] [R11]
      if (fill_cnt_r != 2'h3) begin
        fill_cnt_r <= fill_cnt_r + 2'h1;
      end
    end
  end

  // Transmit-ready waits the full resume time after any exit [R13] [R9]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= slpc_pkg::SLPC_ST_SLEEP;
      wake_cnt_r <= '0;
      tx_ready_r <= 1'b0;
      wake_total_r <= 16'h0000;
    end else begin
      case (state_r)
        slpc_pkg::SLPC_ST_SLEEP: begin
          tx_ready_r <= 1'b0;
          if (!pd_now) begin
            state_r <= slpc_pkg::SLPC_ST_WAKING;
            wake_cnt_r <= '0;
            wake_total_r <= wake_total_r + 16'h0001;
          end
        end
        slpc_pkg::SLPC_ST_WAKING: begin
          if (pd_now) begin
            state_r <= slpc_pkg::SLPC_ST_SLEEP;
          end else if (wake_cnt_r ==
              `SLPC_CNT_W'(`SLPC_RESUME_CYC - 1)) begin
            state_r <= slpc_pkg::SLPC_ST_READY;
            tx_ready_r <= 1'b1; // [R13]
          end else begin
            wake_cnt_r <= wake_cnt_r + `SLPC_CNT_W'(1);
          end
        end
        slpc_pkg::SLPC_ST_READY: begin
          if (pd_now) begin
            state_r <= slpc_pkg::SLPC_ST_SLEEP; // [R2]
            tx_ready_r <= 1'b0;
          end
        end
        default: begin
          state_r <= slpc_pkg::SLPC_ST_SLEEP;
          tx_ready_r <= 1'b0;
        end
      endcase
    end
  end

  // History of line-valid edges: each entry holds the edge direction
  // Ignored until the stages refill, so reset logs no false edge
  assign hist_we = (fill_cnt_r == 2'h3) & (valid_s2_r != valid_d_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hist_ptr_r <= '0;
    end else if (hist_we) begin
      hist_ptr_r <= hist_ptr_r + `SLPC_HIST_AW'(1);
    end
  end

  slpc_hist_mem u_hist (
    .clk_i(clk_i),
    .we_i(hist_we),
    .waddr_i(hist_ptr_r),
    .wdata_i({7'h00, valid_s2_r}),
    .raddr_i(hist_ptr_r - `SLPC_HIST_AW'(1)),
    .rdata_o(hist_rdata)
  );

  // Classic Wishbone slave: ack one cycle after the strobe, one cycle long
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req;
      case (wb_adr_i)
        `SLPC_ADDR_CTRL: dat_r <= ctrl_r;
        `SLPC_ADDR_STAT: dat_r <= {26'h000_0000, tx_ready_r,
          state_r == slpc_pkg::SLPC_ST_SLEEP, valid_s2_r,
          rx_tristate_o, auto_pd_override_o, manual_shutdown_n_o};
        `SLPC_ADDR_WAKE: dat_r <= {16'h0000, wake_total_r};
        `SLPC_ADDR_HIST: dat_r <= {21'h00_0000, hist_ptr_r,
          hist_rdata};
        default: dat_r <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
endmodule
`default_nettype wire

// >>> dv/slpc_host_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module slpc_host_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic manual_shutdown_n_o,
  input wire logic auto_pd_override_o,
  input wire logic rx_tristate_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence unmapped_rd_s;
    req_s ##0 (!wb_we_i && wb_adr_i[1:0] != 2'b00);
  endsequence
  ack_after_req_a: assert property (req_s |=> wb_ack_o)
    else $error("ack missing");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_has_req_a: assert property
    ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  unmapped_reads_zero_a: assert property
    (unmapped_rd_s |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  pins_at_reset_a: assert property (disable iff (1'b0)
    rst_i |=> manual_shutdown_n_o && auto_pd_override_o && !rx_tristate_o)
    else $error("pins wrong in reset");
  manual_keeps_override_a: assert property
    (!manual_shutdown_n_o |-> auto_pd_override_o)
    else $error("override low in manual off");
  shutdown_by_write_a: assert property ($changed(manual_shutdown_n_o)
    |-> $past(wb_we_i && wb_cyc_i, 2))
    else $error("shutdown pin moved unasked");
  override_by_write_a: assert property ($changed(auto_pd_override_o)
    |-> $past(wb_we_i && wb_cyc_i, 2))
    else $error("override pin moved unasked");
endmodule
`default_nettype wire

// >>> dv/slpc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module slpc_dev_model #(
  parameter int IDLE_CYC = 300,
  parameter int VALID_CYC = 10
) (
  input wire logic clk_i,
  input wire logic level_ok_i,
  input wire logic manual_shutdown_n_i,
  input wire logic auto_pd_override_i,
  input wire logic rx_tristate_i,
  output logic line_valid_o,
  output logic tx_on_o,
  output logic rx_on_o
);
  int idle_cnt = 0;
  int ok_cnt = 0;
  logic valid_r = 1'b1;
  assign line_valid_o = valid_r;
  // Level flag from a detector; idle while false
  always @(posedge clk_i) begin
    if (level_ok_i)
      idle_cnt <= 0;
    else if (idle_cnt <= IDLE_CYC)
      idle_cnt <= idle_cnt + 1;
    if (!level_ok_i)
      ok_cnt <= 0;
    else if (ok_cnt < VALID_CYC)
      ok_cnt <= ok_cnt + 1;
  end
  // Indicator ignores every control pin
  always @(posedge clk_i) begin
    if (idle_cnt > IDLE_CYC)
      valid_r <= 1'b0;
    else if (ok_cnt >= VALID_CYC)
      valid_r <= 1'b1;
  end
  // Shutdown wins; auto sleep only with override low
  // Pump and drivers follow, wake is immediate
  assign tx_on_o = manual_shutdown_n_i &&
    (auto_pd_override_i || idle_cnt <= IDLE_CYC);
  assign rx_on_o = !rx_tristate_i;
endmodule
`default_nettype wire

// >>> dv/test_slpc_host.sv
`timescale 1ns/1ps
`default_nettype none
module test_slpc_host;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rd;
  logic [31:0] got;
  logic ack;
  logic lv;
  logic ok = 1'b1;
  logic combined_shutdown_n;
  logic ovr;
  logic rxt;
  logic tx_on;
  logic rx_on;
  logic [2:0] mode_pins [4] = '{3'b110, 3'b100, 3'b010, 3'b110};
  int failures = 0;
  int total_checks = 0;
  always #50 clk_i = ~clk_i;
  slpc_host dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack), .line_valid_i(lv),
    .manual_shutdown_n_o(combined_shutdown_n), .auto_pd_override_o(ovr),
    .rx_tristate_o(rxt));
  slpc_dev_model dev (.clk_i, .level_ok_i(ok), .manual_shutdown_n_i(combined_shutdown_n),
    .auto_pd_override_i(ovr), .rx_tristate_i(rxt), .line_valid_o(lv),
    .tx_on_o(tx_on), .rx_on_o(rx_on));
  // Waits for ack without a limit; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    got = rd;
    cyc <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] m, e);
    bus(1'b0, a, 32'h0000_0000);
    chk(got & m, e);
  endtask
  // Pins are checked two edges after the answer to a control write
  task automatic pins(input logic [2:0] e);
    repeat (2) @(posedge clk_i);
    chk({29'h0, combined_shutdown_n, ovr, rxt}, {29'h0, e});
    chk({31'h0, rx_on}, {31'h0, ~e[0]});
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(4'h0, 32'h0000_000F, 32'h0000_0000);
    pins(3'b110);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 4'h0, 32'(m));
      pins(mode_pins[m]);
      bus(1'b1, 4'h0, 32'(m + 4));
      pins(mode_pins[m] | 3'b001);
    end
    bus(1'b1, 4'h0, 32'h0000_000A);
    pins(3'b011);
    bus(1'b1, 4'h0, 32'h0000_0008);
    pins(3'b110);
    $display("test modes done");
    sel <= 4'h0;
    bus(1'b1, 4'h0, 32'h0000_0002);
    sel <= 4'hF;
    bus(1'b1, 4'h4, 32'h0000_0000);
    rdc(4'h0, 32'h0000_000F, 32'h0000_0008);
    rdc(4'h1, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(4'h4, 32'h0000_001F, 32'h0000_000B);
    $display("test refusals done");
    bus(1'b1, 4'h0, 32'h0000_0001);
    ok <= 1'b0;
    repeat (250) @(posedge clk_i);
    rdc(4'h4, 32'h0000_001F, 32'h0000_0009);
    repeat (80) @(posedge clk_i);
    rdc(4'h4, 32'h0000_001F, 32'h0000_0011);
    chk({31'h0, tx_on}, 32'h0000_0000);
    rdc(4'h8, 32'h0000_FFFF, 32'h0000_0003);
    ok <= 1'b1;
    repeat (20) @(posedge clk_i);
    rdc(4'h4, 32'h0000_003F, 32'h0000_0009);
    chk({31'h0, tx_on}, 32'h0000_0001);
    repeat (1100) @(posedge clk_i);
    rdc(4'h4, 32'h0000_0020, 32'h0000_0020);
    rdc(4'h8, 32'h0000_FFFF, 32'h0000_0004);
    rdc(4'hC, 32'h0000_07FF, 32'h0000_0201);
    $display("test auto powerdown done");
    give_verdict();
  end
  initial begin
    #1000000;
    failures++;
    give_verdict();
  end
endmodule
bind slpc_host slpc_host_monitor mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .manual_shutdown_n_o,
  .auto_pd_override_o, .rx_tristate_o);
`default_nettype wire
